//--- edhd_mode_regs.sv
`timescale 1ns/10ps
`default_nettype none
module edhd_mode_regs (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [edhd_pkg::ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [edhd_pkg::ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic hsyncInN,
  input wire logic vtimingIn,
  input wire logic [9:0] yIn,
  input wire logic [9:0] cbIn,
  input wire logic [9:0] crIn,
  output logic [9:0] lumaOut,
  output logic [9:0] dac2Out,
  output logic [9:0] dac3Out,
  output logic hsyncOut,
  output logic vsyncOut,
  output logic edProtectEnable,
  output logic gammaEnable,
  output logic gammaCurveB,
  output logic adaptiveFilterEnable,
  output logic adaptiveFilterModeB,
  output logic syncComplianceEnable,
  output logic signed [3:0] sharpGainA,
  output logic signed [3:0] sharpGainB,
  output logic [19:0] copyMgmtData
);
  import edhd_pkg::*;

  logic awReady_q, wReady_q, bValid_q, arReady_q, rValid_q;
  logic awDone_q, wDone_q;
  logic [1:0] bResp_q, rResp_q;
  logic [31:0] rData_q;
  logic [9:0] wIdx_q;
  logic [7:0] wByte_q;
  logic wLane_q;
  logic wrEn;
  logic [7:0] rdByte;
  logic rdHit;
  logic [9:0] rdIdx;
  logic [7:0] syncOut_q, tpCtrl_q, timing_q, outFilt_q;
  logic [7:0] luma_q, red_q, blue_q, comply_q, sharp_q;
  logic [7:0] cgmsHi_q, cgmsMid_q, cgmsLo_q;
  logic hsMeta_q, hsSync_q, hsPrev_q;
  logic vtMeta_q, vtSync_q, vtPrev_q;
  logic lineStart, fieldStart;
  logic [H_W-1:0] hCount;
  logic [V_W-1:0] vCount;
  logic hActive, vActive, tpOn, syncOn;
  logic [9:0] pbSel, prSel;
  logic [9:0] luma10_q, dac2_q, dac3_q;
  logic hsyncOut_q, vsyncOut_q;

  // Decode of which indices hold a register
  function automatic logic idxMapped(input logic [9:0] idx);
    idxMapped = (idx == IDX_SYNC_OUT) || (idx == IDX_TP_CTRL) ||
                ((idx >= IDX_TIMING) && (idx <= IDX_COMPLY)) ||
                ((idx >= IDX_SHARP) && (idx <= IDX_CGMS_LO));
  endfunction : idxMapped

  // Write address and data are taken independently, in either order
  always_ff @(posedge clk) begin
    if (!resetn) begin
      awReady_q <= 1'b1;
      awDone_q <= 1'b0;
      wIdx_q <= '0;
    end else if (awvalid && awReady_q) begin
      awReady_q <= 1'b0;
      awDone_q <= 1'b1;
      wIdx_q <= awaddr[11:2];
    end else if (bValid_q && bready) begin
      awReady_q <= 1'b1;
      awDone_q <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      wReady_q <= 1'b1;
      wDone_q <= 1'b0;
      wByte_q <= '0;
      wLane_q <= 1'b0;
    end else if (wvalid && wReady_q) begin
      wReady_q <= 1'b0;
      wDone_q <= 1'b1;
      wByte_q <= wdata[7:0];
      wLane_q <= wstrb[0];
    end else if (bValid_q && bready) begin
      wReady_q <= 1'b1;
      wDone_q <= 1'b0;
    end
  end

  // One write in flight; the register update and bvalid share an edge
  assign wrEn = awDone_q && wDone_q && !bValid_q;

  always_ff @(posedge clk) begin
    if (!resetn) begin
      bValid_q <= 1'b0;
      bResp_q <= RESP_OKAY;
    end else if (wrEn) begin
      bValid_q <= 1'b1;
      bResp_q <= idxMapped(wIdx_q) ? RESP_OKAY : RESP_SLVERR;
    end else if (bValid_q && bready) begin
      bValid_q <= 1'b0;
    end
  end

  // Register bank; only byte lane 0 carries data
  always_ff @(posedge clk) begin
    if (!resetn) begin
      syncOut_q <= RST_SYNC_OUT;
      tpCtrl_q <= RST_TP_CTRL;
      timing_q <= RST_TIMING;
      outFilt_q <= RST_OUTFILT;
      luma_q <= RST_LUMA;
      red_q <= RST_RED;
      blue_q <= RST_BLUE;
      comply_q <= RST_COMPLY;
      sharp_q <= RST_SHARP;
      cgmsHi_q <= RST_CGMS;
      cgmsMid_q <= RST_CGMS;
      cgmsLo_q <= RST_CGMS;
    end else if (wrEn && wLane_q) begin
      unique case (wIdx_q)
        IDX_SYNC_OUT: syncOut_q <= wByte_q & MASK_SYNC_OUT;
        IDX_TP_CTRL: tpCtrl_q <= wByte_q & MASK_TP_CTRL;
        // Reserved bit 5 is dropped so a careless write cannot matter
        IDX_TIMING: timing_q <= wByte_q & MASK_TIMING;
        IDX_OUTFILT: outFilt_q <= wByte_q & MASK_OUTFILT;
        IDX_LUMA: luma_q <= wByte_q;
        IDX_RED: red_q <= wByte_q;
        IDX_BLUE: blue_q <= wByte_q;
        IDX_COMPLY: comply_q <= wByte_q & MASK_COMPLY;
        IDX_SHARP: sharp_q <= wByte_q;
        IDX_CGMS_HI: cgmsHi_q <= wByte_q & MASK_CGMS_HI;
        IDX_CGMS_MID: cgmsMid_q <= wByte_q;
        IDX_CGMS_LO: cgmsLo_q <= wByte_q;
        default: ;
      endcase
    end
  end

  // Read lookup; unmapped indices read zero with an error response
  assign rdIdx = araddr[11:2];
  always_comb begin
    rdByte = 8'h00;
    rdHit = idxMapped(rdIdx);
    unique case (rdIdx)
      IDX_SYNC_OUT: rdByte = syncOut_q;
      IDX_TP_CTRL: rdByte = tpCtrl_q;
      IDX_TIMING: rdByte = timing_q;
      IDX_OUTFILT: rdByte = outFilt_q;
      IDX_LUMA: rdByte = luma_q;
      IDX_RED: rdByte = red_q;
      IDX_BLUE: rdByte = blue_q;
      IDX_COMPLY: rdByte = comply_q;
      IDX_SHARP: rdByte = sharp_q;
      IDX_CGMS_HI: rdByte = cgmsHi_q;
      IDX_CGMS_MID: rdByte = cgmsMid_q;
      IDX_CGMS_LO: rdByte = cgmsLo_q;
      default: rdByte = 8'h00;
    endcase
  end

  // Read channel: answer one cycle after the address is taken
  always_ff @(posedge clk) begin
    if (!resetn) begin
      arReady_q <= 1'b1;
      rValid_q <= 1'b0;
      rData_q <= '0;
      rResp_q <= RESP_OKAY;
    end else if (arvalid && arReady_q) begin
      arReady_q <= 1'b0;
      rValid_q <= 1'b1;
      rData_q <= {24'h000000, rdByte};
      rResp_q <= rdHit ? RESP_OKAY : RESP_SLVERR;
    end else if (rValid_q && rready) begin
      arReady_q <= 1'b1;
      rValid_q <= 1'b0;
    end
  end

  // Pin synchronisers; edges are taken from the second stage only
  always_ff @(posedge clk) begin
    if (!resetn) begin
      hsMeta_q <= 1'b1;
      hsSync_q <= 1'b1;
      hsPrev_q <= 1'b1;
      // Idle high like a vertical sync pin, so no false edge after reset
      vtMeta_q <= 1'b1;
      vtSync_q <= 1'b1;
      vtPrev_q <= 1'b1;
    end else begin
      hsMeta_q <= hsyncInN;
      hsSync_q <= hsMeta_q;
      hsPrev_q <= hsSync_q;
      vtMeta_q <= vtimingIn;
      vtSync_q <= vtMeta_q;
      vtPrev_q <= vtSync_q;
    end
  end

  // Line starts on falling sync; a field pin marks each toggle, or only its fall when BIT_VSYNC_IN is set
  assign lineStart = hsPrev_q && !hsSync_q;
  assign fieldStart = timing_q[BIT_VSYNC_IN] ?
                      (vtPrev_q && !vtSync_q) : (vtPrev_q != vtSync_q);

  edhd_timing_counter u_counter (
    .clk(clk),
    .resetn(resetn),
    .holdCount(timing_q[BIT_TIMING_RST]),
    .freeRun(timing_q[BIT_FREE_RUN]),
    .lineStart(lineStart),
    .fieldStart(fieldStart),
    .hCount(hCount),
    .vCount(vCount)
  );

  assign hActive = hCount < HSYNC_PIXELS;
  assign vActive = vCount < VSYNC_LINES;

  // Sync outputs need both the master enable and their own control bit
  always_ff @(posedge clk) begin
    if (!resetn) begin
      hsyncOut_q <= 1'b0;
      vsyncOut_q <= 1'b0;
    end else begin
      hsyncOut_q <= syncOut_q[BIT_SYNC_OUT_EN] &&
                    timing_q[BIT_HSYNC_CTRL] && hActive;
      vsyncOut_q <= syncOut_q[BIT_SYNC_OUT_EN] &&
                    timing_q[BIT_VSYNC_CTRL] && vActive;
    end
  end

  // Test levels replace video only while the pattern is on
  assign tpOn = tpCtrl_q[BIT_TP_EN];
  assign pbSel = tpOn ? {blue_q, 2'b00} : cbIn;
  assign prSel = tpOn ? {red_q, 2'b00} : crIn;
  assign syncOn = outFilt_q[BIT_SYNC_ON_CD] && hActive;

  // Colour DAC routing, with sync inserted on both difference outputs
  always_ff @(posedge clk) begin
    if (!resetn) begin
      luma10_q <= '0;
      dac2_q <= '0;
      dac3_q <= '0;
    end else begin
      luma10_q <= tpOn ? {luma_q, 2'b00} : yIn;
      if (syncOn) begin
        dac2_q <= CD_SYNC_LEVEL;
        dac3_q <= CD_SYNC_LEVEL;
      end else if (outFilt_q[BIT_DAC_SWAP]) begin
        dac2_q <= prSel;
        dac3_q <= pbSel;
      end else begin
        dac2_q <= pbSel;
        dac3_q <= prSel;
      end
    end
  end

  // Bus outputs
  assign awready = awReady_q;
  assign wready = wReady_q;
  assign bvalid = bValid_q;
  assign bresp = bResp_q;
  assign arready = arReady_q;
  assign rvalid = rValid_q;
  assign rdata = rData_q;
  assign rresp = rResp_q;

  // Video path and control outputs, all taken from registers
  assign lumaOut = luma10_q;
  assign dac2Out = dac2_q;
  assign dac3Out = dac3_q;
  assign hsyncOut = hsyncOut_q;
  assign vsyncOut = vsyncOut_q;
  assign edProtectEnable = timing_q[BIT_ED_PROTECT];
  assign gammaEnable = outFilt_q[BIT_GAMMA_EN];
  assign gammaCurveB = outFilt_q[BIT_GAMMA_SEL];
  assign adaptiveFilterEnable = outFilt_q[BIT_AF_EN];
  assign adaptiveFilterModeB = outFilt_q[BIT_AF_MODE];
  assign syncComplianceEnable = comply_q[BIT_COMPLY];
  assign sharpGainA = sharp_q[3:0];
  assign sharpGainB = sharp_q[7:4];
  assign copyMgmtData = {cgmsHi_q[3:0], cgmsMid_q, cgmsLo_q};

  timing_reset_a: assert property (@(posedge clk)
    !resetn |=> timing_q == 8'h48 && !timing_q[BIT_TIMING_RST])
    else $error("Timing mode register not 0x48 after reset");

  field_mode_a: assert property (@(posedge clk)
    disable iff (!resetn)
    (!timing_q[BIT_VSYNC_IN] && !vtPrev_q && vtSync_q) |-> fieldStart)
    else $error("Field input rise not taken as field start");

  sync_gate_a: assert property (@(posedge clk)
    disable iff (!resetn)
    !syncOut_q[BIT_SYNC_OUT_EN] |=> !hsyncOut_q && !vsyncOut_q)
    else $error("Sync output active while output enable clear");

  dac_swap_a: assert property (@(posedge clk)
    disable iff (!resetn)
    (!syncOn && !tpOn && outFilt_q[BIT_DAC_SWAP])
    |=> dac2_q == $past(crIn) && dac3_q == $past(cbIn))
    else $error("Swapped DAC routing wrong");

  sync_on_cd_a: assert property (@(posedge clk)
    disable iff (!resetn)
    (outFilt_q[BIT_SYNC_ON_CD] && hActive) |=> dac3_q == CD_SYNC_LEVEL)
    else $error("Sync not inserted on difference output");

  gamma_write_a: assert property (@(posedge clk)
    disable iff (!resetn)
    (wrEn && wLane_q && wIdx_q == IDX_OUTFILT)
    |=> gammaCurveB == $past(wByte_q[4]) &&
        gammaEnable == $past(wByte_q[5]))
    else $error("Gamma controls did not follow write");

  tp_bypass_a: assert property (@(posedge clk)
    disable iff (!resetn)
    !tpOn |=> luma10_q == $past(yIn))
    else $error("Test level used while pattern off");

  sharp_write_a: assert property (@(posedge clk)
    disable iff (!resetn)
    (wrEn && wLane_q && wIdx_q == IDX_SHARP)
    |=> sharpGainB == $signed($past(wByte_q[7:4])))
    else $error("Sharpness gain B wrong after write");

  cgms_nibble_a: assert property (@(posedge clk)
    disable iff (!resetn)
    cgmsHi_q[7:4] == 4'h0)
    else $error("Copy data upper nibble not zero");
endmodule : edhd_mode_regs
`default_nettype wire

//--- edhd_pkg.sv
`default_nettype none
package edhd_pkg;
  // Register indices; byte address on the bus is four times the index
  localparam logic [9:0] IDX_SYNC_OUT = 10'h002;
  localparam logic [9:0] IDX_TP_CTRL = 10'h031;
  localparam logic [9:0] IDX_TIMING = 10'h034;
  localparam logic [9:0] IDX_OUTFILT = 10'h035;
  localparam logic [9:0] IDX_LUMA = 10'h036;
  localparam logic [9:0] IDX_RED = 10'h037;
  localparam logic [9:0] IDX_BLUE = 10'h038;
  localparam logic [9:0] IDX_COMPLY = 10'h039;
  localparam logic [9:0] IDX_SHARP = 10'h040;
  localparam logic [9:0] IDX_CGMS_HI = 10'h041;
  localparam logic [9:0] IDX_CGMS_MID = 10'h042;
  localparam logic [9:0] IDX_CGMS_LO = 10'h043;
  localparam int ADDR_W = 12;

  // Values after reset
  localparam logic [7:0] RST_SYNC_OUT = 8'h00;
  localparam logic [7:0] RST_TP_CTRL = 8'h00;
  localparam logic [7:0] RST_TIMING = 8'h48;
  localparam logic [7:0] RST_OUTFILT = 8'h00;
  localparam logic [7:0] RST_LUMA = 8'ha0;
  localparam logic [7:0] RST_RED = 8'h80;
  localparam logic [7:0] RST_BLUE = 8'h80;
  localparam logic [7:0] RST_COMPLY = 8'h00;
  localparam logic [7:0] RST_SHARP = 8'h00;
  localparam logic [7:0] RST_CGMS = 8'h00;

  // Writable bit masks; masked bits read as zero
  localparam logic [7:0] MASK_SYNC_OUT = 8'h80;
  localparam logic [7:0] MASK_TP_CTRL = 8'h04;
  localparam logic [7:0] MASK_TIMING = 8'hdf;
  localparam logic [7:0] MASK_OUTFILT = 8'hfc;
  localparam logic [7:0] MASK_COMPLY = 8'h20;
  localparam logic [7:0] MASK_CGMS_HI = 8'h0f;

  // Field positions
  localparam int BIT_SYNC_OUT_EN = 7;
  localparam int BIT_TP_EN = 2;
  localparam int BIT_TIMING_RST = 0;
  localparam int BIT_HSYNC_CTRL = 1;
  localparam int BIT_VSYNC_CTRL = 2;
  localparam int BIT_ED_PROTECT = 4;
  localparam int BIT_VSYNC_IN = 6;
  localparam int BIT_FREE_RUN = 7;
  localparam int BIT_SYNC_ON_CD = 2;
  localparam int BIT_DAC_SWAP = 3;
  localparam int BIT_GAMMA_SEL = 4;
  localparam int BIT_GAMMA_EN = 5;
  localparam int BIT_AF_MODE = 6;
  localparam int BIT_AF_EN = 7;
  localparam int BIT_COMPLY = 5;

  // Timing counter geometry and sync widths in pixels and lines; sync level for the difference DACs
  localparam int H_W = 12;
  localparam int V_W = 11;
  localparam logic [H_W-1:0] LINE_PIXELS = 12'h35a;
  localparam logic [V_W-1:0] FIELD_LINES = 11'h20d;
  localparam logic [H_W-1:0] HSYNC_PIXELS = 12'h03e;
  localparam logic [V_W-1:0] VSYNC_LINES = 11'h006;
  localparam logic [9:0] CD_SYNC_LEVEL = 10'h040;

  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : edhd_pkg
`default_nettype wire

//--- edhd_timing_counter.sv
`timescale 1ns/10ps
`default_nettype none
module edhd_timing_counter (
  input wire logic clk,
  input wire logic resetn,
  input wire logic holdCount,
  input wire logic freeRun,
  input wire logic lineStart,
  input wire logic fieldStart,
  output logic [edhd_pkg::H_W-1:0] hCount,
  output logic [edhd_pkg::V_W-1:0] vCount
);
  import edhd_pkg::*;

  localparam logic [H_W-1:0] H_LAST = LINE_PIXELS - 12'h001;
  localparam logic [V_W-1:0] V_LAST = FIELD_LINES - 11'h001;

  logic [H_W-1:0] hCount_q;
  logic [V_W-1:0] vCount_q;

  // Horizontal counter: auto wrap or external wrap only
  always_ff @(posedge clk) begin
    if (!resetn || holdCount) begin
      hCount_q <= '0;
    end else if (freeRun) begin
      // Free run wraps on the line sync only; overflow wraps naturally
      hCount_q <= lineStart ? '0 : hCount_q + 12'h001;
    end else begin
      hCount_q <= (hCount_q == H_LAST) ? '0 : hCount_q + 12'h001;
    end
  end

  // Vertical counter advances once per line
  always_ff @(posedge clk) begin
    if (!resetn || holdCount) begin
      vCount_q <= '0;
    end else if (freeRun) begin
      if (fieldStart) begin
        vCount_q <= '0;
      end else if (lineStart) begin
        vCount_q <= vCount_q + 11'h001;
      end
    end else if (hCount_q == H_LAST) begin
      vCount_q <= (vCount_q == V_LAST) ? '0 : vCount_q + 11'h001;
    end
  end

  assign hCount = hCount_q;
  assign vCount = vCount_q;

  hold_clears_a: assert property (@(posedge clk)
    disable iff (!resetn)
    holdCount |=> (hCount_q == '0) && (vCount_q == '0))
    else $error("Timing counters not held at zero");

  auto_wrap_a: assert property (@(posedge clk)
    disable iff (!resetn)
    (!holdCount && !freeRun && hCount_q == H_LAST) |=> hCount_q == '0)
    else $error("Line counter did not wrap at line end");

  free_run_a: assert property (@(posedge clk)
    disable iff (!resetn)
    (!holdCount && freeRun && !lineStart && hCount_q == H_LAST)
    |=> hCount_q == LINE_PIXELS)
    else $error("Free running counter wrapped by itself");

  ext_wrap_a: assert property (@(posedge clk)
    disable iff (!resetn)
    (!holdCount && freeRun && fieldStart) |=> vCount_q == '0)
    else $error("Field sync did not wrap line counter");
endmodule : edhd_timing_counter
`default_nettype wire

//--- edhd_tb.sv
`timescale 1ns/10ps
`default_nettype none
module tb;
  import edhd_pkg::*;

  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic [ADDR_W-1:0] awaddr = '0;
  logic awvalid = 1'b0;
  logic awready;
  logic [31:0] wdata = '0;
  logic [3:0] wstrb = '0;
  logic wvalid = 1'b0;
  logic wready;
  logic [1:0] bresp;
  logic bvalid;
  logic bready = 1'b0;
  logic [ADDR_W-1:0] araddr = '0;
  logic arvalid = 1'b0;
  logic arready;
  logic [31:0] rdata;
  logic [1:0] rresp;
  logic rvalid;
  logic rready = 1'b0;
  logic hsyncInN = 1'b1;
  logic vtimingIn = 1'b1;
  logic [9:0] yIn = 10'h123;
  logic [9:0] cbIn = 10'h2a5;
  logic [9:0] crIn = 10'h15a;
  logic [9:0] lumaOut;
  logic [9:0] dac2Out;
  logic [9:0] dac3Out;
  logic hsyncOut;
  logic vsyncOut;
  logic edProtectEnable;
  logic gammaEnable;
  logic gammaCurveB;
  logic adaptiveFilterEnable;
  logic adaptiveFilterModeB;
  logic syncComplianceEnable;
  logic signed [3:0] sharpGainA;
  logic signed [3:0] sharpGainB;
  logic [19:0] copyMgmtData;
  int err_total = 0;
  int n_tests = 0;
  int pulsePer = 0;

  edhd_mode_regs edhd_mode_regs_inst (.clk, .resetn, .awaddr, .awvalid,
    .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready,
    .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
    .hsyncInN, .vtimingIn, .yIn, .cbIn, .crIn, .lumaOut, .dac2Out, .dac3Out,
    .hsyncOut, .vsyncOut, .edProtectEnable, .gammaEnable, .gammaCurveB,
    .adaptiveFilterEnable, .adaptiveFilterModeB, .syncComplianceEnable,
    .sharpGainA, .sharpGainB, .copyMgmtData);

  // 125 MHz clock
  always #4 clk = ~clk;

  // Line pulses on the horizontal sync pin; period zero keeps it idle high
  initial begin
    forever begin
      @(posedge clk);
      if (pulsePer > 0) begin
        repeat (pulsePer - 5) @(posedge clk);
        hsyncInN <= 1'b0;
        repeat (4) @(posedge clk);
        hsyncInN <= 1'b1;
      end
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic finish_test;
    $display("comparisons %0d, mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : finish_test

  // Handshakes are judged at the falling edge, so the rising edge that
  // follows acts on exactly what the slave samples
  task automatic regWr(input logic [9:0] idx, input logic [7:0] d,
      input logic [3:0] s, output logic [1:0] r);
    int n;
    logic awHit;
    logic wHit;
    logic bHit;
    if (idx == IDX_TIMING) d[5] = 1'b0;
    @(posedge clk);
    awaddr <= {idx, 2'b00};
    awvalid <= 1'b1;
    wdata <= {24'h0, d};
    wstrb <= s;
    wvalid <= 1'b1;
    bready <= 1'b1;
    bHit = 1'b0;
    r = 2'h3;
    for (n = 0; n < 50 && !bHit; n++) begin
      @(negedge clk);
      awHit = awvalid && (awready === 1'b1);
      wHit = wvalid && (wready === 1'b1);
      bHit = bready && (bvalid === 1'b1);
      r = bresp;
      @(posedge clk);
      if (awHit) awvalid <= 1'b0;
      if (wHit) wvalid <= 1'b0;
      if (bHit) bready <= 1'b0;
    end
    if (!bHit) chk(32'h0, 32'h1);
  endtask : regWr

  task automatic regRd(input logic [9:0] idx, output logic [31:0] d,
      output logic [1:0] r);
    int n;
    logic arHit;
    logic rHit;
    @(posedge clk);
    araddr <= {idx, 2'b00};
    arvalid <= 1'b1;
    rready <= 1'b1;
    rHit = 1'b0;
    d = 'x;
    r = 2'h3;
    for (n = 0; n < 50 && !rHit; n++) begin
      @(negedge clk);
      arHit = arvalid && (arready === 1'b1);
      rHit = rready && (rvalid === 1'b1);
      d = rdata;
      r = rresp;
      @(posedge clk);
      if (arHit) arvalid <= 1'b0;
      if (rHit) rready <= 1'b0;
    end
    if (!rHit) chk(32'h0, 32'h1);
  endtask : regRd

  task automatic wr(input logic [9:0] idx, input logic [7:0] d);
    logic [1:0] r;
    regWr(idx, d, 4'h1, r);
    chk(r, RESP_OKAY);
  endtask : wr

  task automatic rd(input logic [9:0] idx, input logic [7:0] exp);
    logic [31:0] d;
    logic [1:0] r;
    regRd(idx, d, r);
    chk(r, RESP_OKAY);
    chk(d, {24'h0, exp});
  endtask : rd

  // Counts falling edges until the chosen sync output rises
  task automatic riseIn(input bit vs, output int n);
    logic prev;
    logic cur;
    prev = vs ? vsyncOut : hsyncOut;
    for (n = 1; n <= 10000; n++) begin
      @(negedge clk);
      cur = vs ? vsyncOut : hsyncOut;
      if (cur === 1'b1 && prev === 1'b0) break;
      prev = cur;
    end
  endtask : riseIn

  task automatic t_reset;
    logic [9:0] ix [12] = '{IDX_SYNC_OUT, IDX_TP_CTRL, IDX_TIMING,
      IDX_OUTFILT, IDX_LUMA, IDX_RED, IDX_BLUE, IDX_COMPLY, IDX_SHARP,
      IDX_CGMS_HI, IDX_CGMS_MID, IDX_CGMS_LO};
    logic [7:0] ev [12] = '{8'h00, 8'h00, 8'h48, 8'h00, 8'ha0, 8'h80,
      8'h80, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    logic [31:0] d;
    logic [1:0] r;
    for (int i = 0; i < 12; i++) rd(ix[i], ev[i]);
    regRd(10'h03a, d, r);
    chk(r, RESP_SLVERR);
    chk(copyMgmtData, 32'h0);
    chk({edProtectEnable, syncComplianceEnable}, 32'h0);
  endtask : t_reset

  task automatic t_fields;
    logic [1:0] r;
    wr(IDX_TIMING, 8'hdf);
    rd(IDX_TIMING, 8'hdf);
    chk(edProtectEnable, 32'h1);
    wr(IDX_TIMING, 8'h48);
    wr(IDX_OUTFILT, 8'hff);
    rd(IDX_OUTFILT, 8'hfc);
    chk({gammaEnable, gammaCurveB}, 32'h3);
    chk({adaptiveFilterEnable, adaptiveFilterModeB}, 32'h3);
    wr(IDX_OUTFILT, 8'h20);
    chk({gammaEnable, gammaCurveB}, 32'h2);
    chk({adaptiveFilterEnable, adaptiveFilterModeB}, 32'h0);
    wr(IDX_SHARP, 8'h87);
    chk({28'h0, sharpGainA}, 32'h7);
    chk({28'h0, sharpGainB}, 32'h8);
    chk(sharpGainB < 0, 32'h1);
    wr(IDX_CGMS_HI, 8'hfa);
    wr(IDX_CGMS_MID, 8'h5c);
    wr(IDX_CGMS_LO, 8'h3e);
    rd(IDX_CGMS_HI, 8'h0a);
    chk(copyMgmtData, 32'ha5c3e);
    regWr(IDX_CGMS_MID, 8'h11, 4'h0, r);
    regWr(10'h03b, 8'h11, 4'h1, r);
    chk(r, RESP_SLVERR);
    chk(copyMgmtData, 32'ha5c3e);
  endtask : t_fields

  // Colour levels land on the difference DACs only while the pattern is on
  task automatic t_testpat;
    repeat (3) @(negedge clk);
    chk(lumaOut, 32'h123);
    wr(IDX_TP_CTRL, 8'h04);
    repeat (3) @(negedge clk);
    chk(lumaOut, 32'h280);
    wr(IDX_LUMA, 8'h55);
    repeat (3) @(negedge clk);
    chk(lumaOut, 32'h154);
    wr(IDX_RED, 8'h33);
    repeat (3) @(negedge clk);
    chk({dac2Out, dac3Out}, {12'h0, 10'h200, 10'h0cc});
    wr(IDX_TP_CTRL, 8'h00);
    repeat (3) @(negedge clk);
    chk(lumaOut, 32'h123);
    chk({dac2Out, dac3Out}, {12'h0, cbIn, crIn});
  endtask : t_testpat

  // Counters held in reset keep both syncs in their active region
  task automatic t_held;
    wr(IDX_SYNC_OUT, 8'h80);
    wr(IDX_TIMING, 8'h4f);
    repeat (4) begin
      repeat (300) @(negedge clk);
      chk({hsyncOut, vsyncOut}, 32'h3);
    end
    wr(IDX_OUTFILT, 8'h04);
    repeat (3) @(negedge clk);
    chk({dac2Out, dac3Out}, {12'h0, 10'h040, 10'h040});
    wr(IDX_OUTFILT, 8'h00);
    repeat (3) @(negedge clk);
    chk({dac2Out, dac3Out}, {12'h0, cbIn, crIn});
    wr(IDX_OUTFILT, 8'h08);
    repeat (3) @(negedge clk);
    chk({dac2Out, dac3Out}, {12'h0, crIn, cbIn});
    wr(IDX_SYNC_OUT, 8'h00);
    repeat (4) @(negedge clk);
    chk({hsyncOut, vsyncOut}, 32'h0);
    wr(IDX_SYNC_OUT, 8'h80);
    repeat (4) @(negedge clk);
    chk({hsyncOut, vsyncOut}, 32'h3);
  endtask : t_held

  task automatic t_wrap;
    int n;
    wr(IDX_TIMING, 8'h4e);
    riseIn(1'b0, n);
    riseIn(1'b0, n);
    chk(n, 32'd858);
    wr(IDX_TIMING, 8'hce);
    riseIn(1'b0, n);
    riseIn(1'b0, n);
    chk(n, 32'd4096);
    pulsePer = 1000;
    repeat (3) riseIn(1'b0, n);
    chk(n, 32'd1000);
  endtask : t_wrap

  task automatic t_vin;
    int n;
    pulsePer = 200;
    wr(IDX_TIMING, 8'h8c);
    @(posedge clk);
    vtimingIn <= 1'b0;
    repeat (2000) @(negedge clk);
    chk(vsyncOut, 32'h0);
    @(posedge clk);
    vtimingIn <= 1'b1;
    riseIn(1'b1, n);
    chk(n <= 20, 32'h1);
    wr(IDX_TIMING, 8'hcc);
    repeat (2000) @(negedge clk);
    chk(vsyncOut, 32'h0);
    @(posedge clk);
    vtimingIn <= 1'b0;
    riseIn(1'b1, n);
    chk(n <= 20, 32'h1);
    repeat (2000) @(negedge clk);
    @(posedge clk);
    vtimingIn <= 1'b1;
    riseIn(1'b1, n);
    chk(n > 50, 32'h1);
  endtask : t_vin

  // Watchdog well beyond the expected run of about 30000 cycles
  initial begin
    #640000;
    err_total++;
    finish_test();
  end

  // Main sequence
  initial begin
    repeat (20) @(posedge clk);
    resetn <= 1'b1;
    t_reset();
    t_fields();
    t_testpat();
    t_held();
    t_wrap();
    t_vin();
    finish_test();
  end
endmodule : tb
`default_nettype wire
